//--- rtl/ads_top.sv
// axis drive status block: wishbone slave, command decode and per-axis status
// Function
// - every axis keeps its own status word and a read returns the one of the last selected axis.
// - bit 0 shows position at or above the plus compare value, bit 1 position below the minus one.
// - bits 2, 3 and 4 show accelerating, constant speed and decelerating during a drive.
// - bits 5, 6 and 7 show the S-curve jerk phase rising, flat and falling.
// - bits 8 to 10 latch when one of the three external decelerating stop inputs ended the drive.
// - bits 12 and 13 latch when the plus or minus limit input ended the drive.
// - bits 14 and 15 latch when the servo alarm or the low emergency input ended the drive.
// - a drive ends on pulses done, a stop command, soft limit, external stop, limit, alarm or emergency.
// - input-caused stop details stay latched until the next drive command or the clear command.
// - once the drive is over, any set cause bit 12 to 15 raises the axis error flag in the main word.
// - the cause bits clear on the next drive command or on the finishing-status clear command.
// - a soft limit stop stays visible in the error detail after the drive has finished.
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`default_nettype none
`include "ads_defs.svh"
module ads_top #(
  parameter int NUM_AXES = 2,
  parameter int POS_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_AXES*POS_W-1:0] position_i,
  input wire logic [NUM_AXES-1:0] pulse_done_i,
  input wire logic [NUM_AXES*3-1:0] phase_i,
  input wire logic [NUM_AXES*3-1:0] jerk_i,
  input wire logic [NUM_AXES*3-1:0] ext_decel_stop_inputs_n_i,
  input wire logic [NUM_AXES-1:0] plus_limit_input_n_i,
  input wire logic [NUM_AXES-1:0] minus_limit_input_n_i,
  input wire logic [NUM_AXES-1:0] servo_alarm_input_n_i,
  input wire logic emergency_input_low_i,
  output logic [NUM_AXES-1:0] drive_active_o,
  output logic [NUM_AXES-1:0] drive_start_o,
  output logic [NUM_AXES-1:0] drive_end_o,
  output logic irq_o
);
  import ads_pkg::*;

  localparam int SEL_W = (NUM_AXES > 1) ? $clog2(NUM_AXES) : 1;
  localparam int N_EV = 2 * NUM_AXES;

  // byte-lane merge for partial writes
  function automatic logic [31:0] ads_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : ads_merge

  // bus handshake state
  ads_bus_state_t bus_q, bus_d;
  logic ack_d;
  logic [31:0] rdata_d;
  logic req_take, wr_take;

  // command decode
  logic cmd_we;
  logic [7:0] cmd_code;
  logic [NUM_AXES-1:0] cmd_mask;
  logic [NUM_AXES-1:0] start_v, decel_v, sudden_v, clear_v;
  logic dir_minus;

  // axis selection and software registers
  logic [SEL_W-1:0] sel_q, sel_d;
  logic [4:0] cfg_q, cfg_d;
  logic [POS_W-1:0] cmp_plus_q [NUM_AXES];
  logic [POS_W-1:0] cmp_plus_d [NUM_AXES];
  logic [POS_W-1:0] cmp_minus_q [NUM_AXES];
  logic [POS_W-1:0] cmp_minus_d [NUM_AXES];

  // per-axis results
  logic [15:0] axis_status [NUM_AXES];
  logic [5:0] axis_detail [NUM_AXES];
  logic [NUM_AXES-1:0] axis_error, axis_finish, axis_err_stop;

  // interrupt block
  logic irq_clr_we, irq_mask_we;
  logic [N_EV-1:0] irq_status, irq_mask;

  always_comb begin
    req_take = (bus_q == BUS_IDLE) & wb_cyc_i & wb_stb_i;
    wr_take = req_take & wb_we_i;
    bus_d = bus_q;
    unique case (bus_q)
      BUS_IDLE: begin
        if (req_take) begin
          bus_d = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_d = BUS_IDLE;
      end
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
    ack_d = req_take;
  end

  always_comb begin
    cmd_we = wr_take & (wb_adr_i == `ADS_OFF_COMMAND) & (&wb_sel_i[1:0]);
    cmd_code = wb_dat_i[7:0];
    cmd_mask = wb_dat_i[`ADS_CMD_MASK_LSB +: NUM_AXES];
    dir_minus = (cmd_code == `ADS_CMD_DRIVE_MINUS);
    for (int i = 0; i < NUM_AXES; i++) begin
      start_v[i] = cmd_we & cmd_mask[i]
                 & ((cmd_code == `ADS_CMD_DRIVE_PLUS) | (cmd_code == `ADS_CMD_DRIVE_MINUS));
      decel_v[i] = cmd_we & cmd_mask[i] & (cmd_code == `ADS_CMD_DECEL_STOP);
      sudden_v[i] = cmd_we & cmd_mask[i] & (cmd_code == `ADS_CMD_SUDDEN_STOP);
      clear_v[i] = cmd_we & cmd_mask[i] & (cmd_code == `ADS_CMD_CLEAR);
    end
  end

  // any command naming axes moves the read selection; an empty mask keeps the old one
  always_comb begin
    sel_d = sel_q;
    if (cmd_we) begin
      for (int i = NUM_AXES - 1; i >= 0; i--) begin
        if (cmd_mask[i]) begin
          sel_d = SEL_W'(i);
        end
      end
    end
  end

  always_comb begin
    logic [31:0] cfg_w;
    cfg_w = ads_merge({27'h0, cfg_q}, wb_dat_i, wb_sel_i);
    cfg_d = cfg_q;
    if (wr_take & (wb_adr_i == `ADS_OFF_CONFIG)) begin
      cfg_d = cfg_w[4:0];
    end
    for (int i = 0; i < NUM_AXES; i++) begin
      cmp_plus_d[i] = cmp_plus_q[i];
      cmp_minus_d[i] = cmp_minus_q[i];
      if (wr_take & (SEL_W'(i) == sel_q) & (wb_adr_i == `ADS_OFF_CMP_PLUS)) begin
        cmp_plus_d[i] = POS_W'(ads_merge(32'(cmp_plus_q[i]), wb_dat_i, wb_sel_i));
      end
      if (wr_take & (SEL_W'(i) == sel_q) & (wb_adr_i == `ADS_OFF_CMP_MINUS)) begin
        cmp_minus_d[i] = POS_W'(ads_merge(32'(cmp_minus_q[i]), wb_dat_i, wb_sel_i));
      end
    end
  end

  always_comb begin
    irq_clr_we = wr_take & (wb_adr_i == `ADS_OFF_IRQ_STAT) & wb_sel_i[0];
    irq_mask_we = wr_take & (wb_adr_i == `ADS_OFF_IRQ_MASK) & wb_sel_i[0];
  end

  // read mux; reads have no side effect on any status bit
  always_comb begin
    rdata_d = '0;
    if (req_take & ~wb_we_i) begin
      unique case (wb_adr_i)
        `ADS_OFF_STATUS_ONE: rdata_d = {16'h0, axis_status[sel_q]};
        `ADS_OFF_MAIN: begin
          // main word holds up to four axes per field
          rdata_d[`ADS_MAIN_DRV_LSB +: NUM_AXES] = drive_active_o;
          rdata_d[`ADS_MAIN_ERR_LSB +: NUM_AXES] = axis_error;
        end
        `ADS_OFF_DETAIL: rdata_d = {26'h0, axis_detail[sel_q]};
        `ADS_OFF_CONFIG: rdata_d = {27'h0, cfg_q};
        `ADS_OFF_CMP_PLUS: rdata_d = 32'(cmp_plus_q[sel_q]);
        `ADS_OFF_CMP_MINUS: rdata_d = 32'(cmp_minus_q[sel_q]);
        `ADS_OFF_IRQ_STAT: rdata_d = 32'(irq_status);
        `ADS_OFF_IRQ_MASK: rdata_d = 32'(irq_mask);
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      sel_q <= '0;
      cfg_q <= `ADS_CFG_RESET;
    end else begin
      bus_q <= bus_d;
      wb_ack_o <= ack_d;
      wb_dat_o <= rdata_d;
      sel_q <= sel_d;
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_AXES; i++) begin
      if (rst_i) begin
        cmp_plus_q[i] <= POS_W'(`ADS_CMP_RESET);
        cmp_minus_q[i] <= POS_W'(`ADS_CMP_RESET);
      end else begin
        cmp_plus_q[i] <= cmp_plus_d[i];
        cmp_minus_q[i] <= cmp_minus_d[i];
      end
    end
  end

  // one status word per axis, each with its own latches
  for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
    ads_axis #(
      .POS_W(POS_W)
    ) u_axis (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(start_v[g]),
      .dir_minus_i(dir_minus),
      .decel_cmd_i(decel_v[g]),
      .sudden_cmd_i(sudden_v[g]),
      .clear_i(clear_v[g]),
      .slmt_en_i(cfg_q[`ADS_CFG_SLMT_EN]),
      .ext_en_i(cfg_q[`ADS_CFG_EXT_LSB +: 3]),
      .alarm_en_i(cfg_q[`ADS_CFG_ALARM_EN]),
      .position_i(position_i[g*POS_W +: POS_W]),
      .cmp_plus_i(cmp_plus_q[g]),
      .cmp_minus_i(cmp_minus_q[g]),
      .pulse_done_i(pulse_done_i[g]),
      .phase_i(phase_i[g*3 +: 3]),
      .jerk_i(jerk_i[g*3 +: 3]),
      .ext_decel_stop_inputs_n_i(ext_decel_stop_inputs_n_i[g*3 +: 3]),
      .plus_limit_input_n_i(plus_limit_input_n_i[g]),
      .minus_limit_input_n_i(minus_limit_input_n_i[g]),
      .servo_alarm_input_n_i(servo_alarm_input_n_i[g]),
      .emergency_input_low_i(emergency_input_low_i),
      .active_o(drive_active_o[g]),
      .start_o(drive_start_o[g]),
      .finish_o(axis_finish[g]),
      .err_stop_o(axis_err_stop[g]),
      .error_o(axis_error[g]),
      .status_o(axis_status[g]),
      .detail_o(axis_detail[g])
    );
  end

  // drive end is exported as the same registered pulse that feeds the interrupt
  assign drive_end_o = axis_finish;

  ads_irq #(
    .N_EV(N_EV)
  ) u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i({axis_err_stop, axis_finish}),
    .clr_we_i(irq_clr_we),
    .clr_data_i(wb_dat_i[N_EV-1:0]),
    .mask_we_i(irq_mask_we),
    .mask_data_i(wb_dat_i[N_EV-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );
endmodule : ads_top
`default_nettype wire

//--- rtl/ads_defs.svh
// register offsets, command codes and field positions of the axis drive status block
`ifndef ADS_DEFS_SVH
`define ADS_DEFS_SVH
`define ADS_OFF_COMMAND 8'h00
`define ADS_OFF_STATUS_ONE 8'h04
`define ADS_OFF_MAIN 8'h08
`define ADS_OFF_DETAIL 8'h0c
`define ADS_OFF_CONFIG 8'h10
`define ADS_OFF_CMP_PLUS 8'h14
`define ADS_OFF_CMP_MINUS 8'h18
`define ADS_OFF_IRQ_STAT 8'h1c
`define ADS_OFF_IRQ_MASK 8'h20
`define ADS_CMD_AXIS_SELECT 8'h0f
`define ADS_CMD_DRIVE_PLUS 8'h20
`define ADS_CMD_DRIVE_MINUS 8'h21
`define ADS_CMD_CLEAR 8'h25
`define ADS_CMD_DECEL_STOP 8'h26
`define ADS_CMD_SUDDEN_STOP 8'h27
`define ADS_CMD_MASK_LSB 8
`define ADS_ST_ABOVE 0
`define ADS_ST_BELOW 1
`define ADS_ST_PHASE_LSB 2
`define ADS_ST_JERK_LSB 5
`define ADS_ST_EXT_LSB 8
`define ADS_ST_UNUSED 11
`define ADS_ST_CAUSE_LSB 12
`define ADS_DT_SLMT_PLUS 0
`define ADS_DT_SLMT_MINUS 1
`define ADS_DT_HW_LSB 2
`define ADS_CFG_SLMT_EN 0
`define ADS_CFG_EXT_LSB 1
`define ADS_CFG_ALARM_EN 4
`define ADS_CFG_RESET 5'h00
`define ADS_CMP_RESET 32'h0000_0000
`define ADS_MAIN_DRV_LSB 0
`define ADS_MAIN_ERR_LSB 4
`endif

//--- rtl/ads_pkg.sv
// types shared by the axis drive status block
`default_nettype none
package ads_pkg;
  typedef logic [2:0] ads_phase_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } ads_bus_state_t;
endpackage : ads_pkg
`default_nettype wire

//--- rtl/ads_irq.sv
// sticky event bits, mask and level interrupt output
`default_nettype none
module ads_irq #(
  parameter int N_EV = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N_EV-1:0] set_i,
  input wire logic clr_we_i,
  input wire logic [N_EV-1:0] clr_data_i,
  input wire logic mask_we_i,
  input wire logic [N_EV-1:0] mask_data_i,
  output logic [N_EV-1:0] status_o,
  output logic [N_EV-1:0] mask_o,
  output logic irq_o
);
  import ads_pkg::*;
  logic [N_EV-1:0] status_d;
  logic [N_EV-1:0] mask_d;
  logic irq_d;

  always_comb begin
    // a new event in the clearing cycle survives the clear
    status_d = (status_o & ~(clr_we_i ? clr_data_i : '0)) | set_i;
    mask_d = mask_we_i ? mask_data_i : mask_o;
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= '0;
      mask_o <= '0;
      irq_o <= 1'b0;
    end else begin
      status_o <= status_d;
      mask_o <= mask_d;
      irq_o <= irq_d;
    end
  end
endmodule : ads_irq
`default_nettype wire

//--- rtl/ads_axis.sv
// one axis: drive state, stop-cause latches, error detail and status word
`default_nettype none
`include "ads_defs.svh"
module ads_axis #(
  parameter int POS_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic dir_minus_i,
  input wire logic decel_cmd_i,
  input wire logic sudden_cmd_i,
  input wire logic clear_i,
  input wire logic slmt_en_i,
  input wire logic [2:0] ext_en_i,
  input wire logic alarm_en_i,
  input wire logic signed [POS_W-1:0] position_i,
  input wire logic signed [POS_W-1:0] cmp_plus_i,
  input wire logic signed [POS_W-1:0] cmp_minus_i,
  input wire logic pulse_done_i,
  input wire ads_pkg::ads_phase_t phase_i,
  input wire ads_pkg::ads_phase_t jerk_i,
  input wire logic [2:0] ext_decel_stop_inputs_n_i,
  input wire logic plus_limit_input_n_i,
  input wire logic minus_limit_input_n_i,
  input wire logic servo_alarm_input_n_i,
  input wire logic emergency_input_low_i,
  output logic active_o,
  output logic start_o,
  output logic finish_o,
  output logic err_stop_o,
  output logic error_o,
  output logic [15:0] status_o,
  output logic [5:0] detail_o
);
  import ads_pkg::*;
  logic dir_q, dir_d, active_d, start_d, finish_d, err_stop_d, error_d;
  logic [6:0] cause_q, cause_d, cause_set;
  logic [5:0] detail_d, detail_set;
  logic [15:0] status_d;
  logic above, below, slmt_p, slmt_m, lim_p, lim_m, alm, emergency_cause, any_stop, ending, starting, clr;
  logic [2:0] ext_hit;

  always_comb begin
    above = position_i >= cmp_plus_i;
    below = position_i < cmp_minus_i;
    slmt_p = slmt_en_i & ~dir_q & above;
    slmt_m = slmt_en_i & dir_q & (position_i <= cmp_minus_i);
    ext_hit = ext_en_i & ~ext_decel_stop_inputs_n_i;
    lim_p = ~plus_limit_input_n_i;
    lim_m = ~minus_limit_input_n_i;
    alm = alarm_en_i & ~servo_alarm_input_n_i;
    emergency_cause = ~emergency_input_low_i;
    any_stop = pulse_done_i | decel_cmd_i | sudden_cmd_i | slmt_p | slmt_m | (|ext_hit)
             | lim_p | lim_m | alm | emergency_cause;
    ending = active_o & any_stop;
    starting = start_i & ~active_o;
    // a drive command refused while running does not clear the causes
    clr = clear_i | starting;
    cause_set = {emergency_cause, alm, lim_m, lim_p, ext_hit} & {7{ending}};
    detail_set = {emergency_cause, alm, lim_m, lim_p, slmt_m, slmt_p} & {6{ending}};
    cause_d = (cause_q & ~{7{clr}}) | cause_set;
    detail_d = (detail_o & ~{6{clr}}) | detail_set;
    active_d = starting | (active_o & ~ending);
    dir_d = starting ? dir_minus_i : dir_q;
    start_d = starting;
    finish_d = ending;
    err_stop_d = |{cause_set, detail_set};
    error_d = ~active_d & ((|cause_d[6:3]) | (|detail_d));
    status_d = '0;
    status_d[`ADS_ST_ABOVE] = above;
    status_d[`ADS_ST_BELOW] = below;
    status_d[`ADS_ST_PHASE_LSB +: 3] = phase_i & {3{active_d}};
    status_d[`ADS_ST_JERK_LSB +: 3] = jerk_i & {3{active_d}};
    status_d[`ADS_ST_EXT_LSB +: 3] = cause_d[2:0];
    status_d[`ADS_ST_UNUSED] = 1'b0;
    status_d[`ADS_ST_CAUSE_LSB +: 4] = cause_d[6:3];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_q <= 1'b0;
      active_o <= 1'b0;
      start_o <= 1'b0;
      finish_o <= 1'b0;
      err_stop_o <= 1'b0;
      error_o <= 1'b0;
      cause_q <= '0;
      detail_o <= '0;
      status_o <= '0;
    end else begin
      dir_q <= dir_d;
      active_o <= active_d;
      start_o <= start_d;
      finish_o <= finish_d;
      err_stop_o <= err_stop_d;
      error_o <= error_d;
      cause_q <= cause_d;
      detail_o <= detail_d;
      status_o <= status_d;
    end
  end
endmodule : ads_axis
`default_nettype wire

//--- testbench/ads_top_assertions.sv
// port-level checks of the axis drive status block
`default_nettype none
module ads_chk #(
  parameter int NUM_AXES = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [NUM_AXES-1:0] pulse_done_i,
  input wire logic [NUM_AXES-1:0] plus_limit_input_n_i,
  input wire logic emergency_input_low_i,
  input wire logic [NUM_AXES-1:0] drive_active_o,
  input wire logic [NUM_AXES-1:0] drive_start_o,
  input wire logic [NUM_AXES-1:0] drive_end_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_req_answered: assert property (s_req |=> s_ack) else $error("no single ack");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_unused_zero: assert property (wb_ack_o && $past(wb_adr_i) == 8'h04 &&
    !$past(wb_we_i) |-> !wb_dat_o[11]) else $error("unused bit set");
  a_done_ends: assert property (drive_active_o[0] && pulse_done_i[0] |=>
    drive_end_o[0] && !drive_active_o[0]) else $error("done did not end drive");
  a_limit_ends: assert property (drive_active_o[0] && !plus_limit_input_n_i[0] |=>
    drive_end_o[0]) else $error("limit did not end drive");
  a_emg_ends: assert property (drive_active_o[0] && !emergency_input_low_i |=>
    !drive_active_o[0]) else $error("emergency did not end drive");
  a_end_pulse: assert property (drive_end_o[0] |-> $past(drive_active_o[0]) &&
    !drive_active_o[0] ##1 !drive_end_o[0]) else $error("bad end pulse");
  a_start_pulse: assert property (drive_start_o[0] |-> drive_active_o[0]
    ##1 !drive_start_o[0]) else $error("bad start pulse");
endmodule : ads_chk
bind ads_top ads_chk #(.NUM_AXES(NUM_AXES)) chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .pulse_done_i, .plus_limit_input_n_i,
  .emergency_input_low_i, .drive_active_o, .drive_start_o, .drive_end_o);
`default_nettype wire

//--- testbench/ads_field.sv
// field side of axis 0: stop, limit and alarm inputs plus the shared emergency line
`default_nettype none
module ads_field (
  input wire logic clk_i,
  input wire logic [6:0] req_i,
  output logic [2:0] stop_n_o,
  output logic plim_n_o,
  output logic mlim_n_o,
  output logic alarm_n_o,
  output logic emg_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // all lines idle high so nothing stops a drive before the bench asks
  logic [6:0] act_n_q = 7'h7f;
  always_ff @(posedge clk_i) begin
    act_n_q <= ~req_i;
  end
  assign stop_n_o = act_n_q[2:0];
  assign plim_n_o = act_n_q[3];
  assign mlim_n_o = act_n_q[4];
  assign alarm_n_o = act_n_q[5];
  assign emg_n_o = act_n_q[6];
endmodule : ads_field
`default_nettype wire

//--- testbench/tb_ads_top.sv
// self-checking bench for the axis drive status block
`default_nettype none
module tb_ads_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, plim_n, mlim_n, alarm_n, emg_n, irq;
  logic [63:0] pos = 64'h0;
  logic [1:0] pdone = 2'h0;
  logic [5:0] ph = 6'h0;
  logic [5:0] jk = 6'h0;
  logic [6:0] req = 7'h0;
  logic [2:0] stop_n;
  logic [1:0] act, st, en;
  int bad_count = 0;
  int cmp_count = 0;
  initial forever #2 clk_i = ~clk_i;
  ads_top #(.NUM_AXES(2), .POS_W(32)) dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .position_i(pos),
    .pulse_done_i(pdone), .phase_i(ph), .jerk_i(jk),
    .ext_decel_stop_inputs_n_i({3'h7, stop_n}), .plus_limit_input_n_i({1'b1, plim_n}),
    .minus_limit_input_n_i({1'b1, mlim_n}), .servo_alarm_input_n_i({1'b1, alarm_n}),
    .emergency_input_low_i(emg_n), .drive_active_o(act), .drive_start_o(st),
    .drive_end_o(en), .irq_o(irq));
  ads_field fld_u (.clk_i, .req_i(req), .stop_n_o(stop_n), .plim_n_o(plim_n),
    .mlim_n_o(mlim_n), .alarm_n_o(alarm_n), .emg_n_o(emg_n));
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // the ack edge is the only place read data is taken
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n == 20) bad_count++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic wait_end();
    int n;
    n = 0;
    while (en[0] !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, en[0]}, 32'h1);
  endtask : wait_end
  task automatic t_reset();
    rdc(8'h04, 32'h1);
    rdc(8'h08, 32'h0);
    rdc(8'h10, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rdc(8'h40, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_cmp();
    logic [31:0] p [4] = '{32'd100, 32'd99, 32'hffff_fffa, 32'hffff_fffb};
    logic [31:0] e [4] = '{32'h1, 32'h0, 32'h2, 32'h0};
    wr(8'h14, 32'd100);
    wr(8'h18, 32'hffff_fffb);
    foreach (p[i]) begin
      pos[31:0] <= p[i];
      rdc(8'h04, e[i]);
    end
    pos[63:32] <= 32'd7;
    wr(8'h00, 32'h020f);
    rdc(8'h04, 32'h1);
    wr(8'h00, 32'h010f);
    rdc(8'h04, 32'h0);
    wr(8'h14, 32'd1000);
    wr(8'h18, 32'hffff_fc18);
    pos[31:0] <= 32'h0;
    $display("test compare done");
  endtask : t_cmp
  task automatic t_phase();
    for (int j = 0; j < 3; j++) begin
      wr(8'h00, 32'h0120);
      rdc(8'h08, 32'h1);
      for (int i = 0; i < 3; i++) begin
        ph[2:0] <= 3'b001 << i;
        jk[2:0] <= 3'b001 << i;
        rdc(8'h04, (32'h4 << i) | (32'h20 << i));
      end
      if (j == 0) begin
        pdone[0] <= 1'b1;
        wait_end();
        pdone[0] <= 1'b0;
      end else wr(8'h00, 32'h0125 + j);
      rdc(8'h04, 32'h0);
      rdc(8'h08, 32'h0);
    end
    $display("test phase done");
  endtask : t_phase
  task automatic t_cause();
    int idx [7] = '{8, 9, 10, 12, 13, 14, 15};
    wr(8'h10, 32'h1f);
    wr(8'h20, 32'h4);
    foreach (idx[k]) begin
      wr(8'h00, 32'h0120);
      req <= 7'h1 << k;
      wait_end();
      req <= 7'h0;
      rdc(8'h04, 32'h1 << idx[k]);
      rdc(8'h04, 32'h1 << idx[k]);
      rdc(8'h08, idx[k] > 11 ? 32'h10 : 32'h0);
      // every input-caused stop counts as an error end, external stops included
      rdc(8'h1c, 32'h5);
      chk({31'h0, irq}, 32'h1);
      wr(8'h1c, 32'hf);
      rdc(8'h1c, 32'h0);
      chk({31'h0, irq}, 32'h0);
      if (k % 2 == 0) wr(8'h00, 32'h0125);
      else begin
        wr(8'h00, 32'h0120);
        wr(8'h00, 32'h0127);
      end
      rdc(8'h04, 32'h0);
      rdc(8'h08, 32'h0);
    end
    $display("test cause done");
  endtask : t_cause
  task automatic t_soft();
    wr(8'h14, 32'd10);
    pos[31:0] <= 32'd20;
    wr(8'h00, 32'h0120);
    wait_end();
    rdc(8'h0c, 32'h1);
    rdc(8'h04, 32'h1);
    rdc(8'h08, 32'h10);
    wr(8'h00, 32'h0125);
    rdc(8'h0c, 32'h0);
    // minus drive onto the minus compare value: the equal case must already stop
    pos[31:0] <= 32'hffff_fc18;
    wr(8'h00, 32'h0121);
    wait_end();
    rdc(8'h0c, 32'h2);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h10);
    wr(8'h00, 32'h0125);
    rdc(8'h0c, 32'h0);
    $display("test soft limit done");
  endtask : t_soft
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_cmp();
    t_phase();
    t_cause();
    t_soft();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    results();
  end
endmodule : tb_ads_top
`default_nettype wire
